/* tksrp_rx.sv */
/*
  Shared constants for the touch-key serial reply port, and the auto-baud
  request receiver that measures the bit period from the request character.
  Assumes the line input is already synchronised to CLK_SYS and idles high.
*/
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// Constants
package tksrp_pkg;
  localparam int          CLK_HZ      = 200_000_000;
  localparam int          BAUD_MIN    = 8000;
  localparam int          BAUD_MAX    = 38400;
  localparam int          TOL_PCT     = 25;   // Slack for host rate error
  localparam int          LOW_BITS    = 5;    // Start plus four low bits
  localparam int          TURN_BITS   = 2;    // Turnaround from mid stop
  localparam int          FRAME_BITS  = 10;
  localparam int          KEY_N       = 10;
  localparam int          KEY_LO_N    = 6;    // Keys in the first byte
  localparam int          PER_W       = 16;
  localparam int          CNT_W       = 19;
  localparam logic [7:0]  REQ_CHAR    = 8'h50;
  localparam logic [7:0]  IDLE_REPLY  = 8'h40;
  localparam logic [3:0]  FIRST_HIGH  = 4'h5; // First bit checked by value
  localparam logic [3:0]  STOP_IDX    = 4'h9;
  localparam int BIT_CYC_MAX = CLK_HZ / BAUD_MIN;
  localparam int BIT_CYC_MIN = (CLK_HZ + BAUD_MAX - 1) / BAUD_MAX;
  localparam int LOW_MAX_CYC = BIT_CYC_MAX * LOW_BITS * (100 + TOL_PCT) / 100;
  localparam int LOW_MIN_CYC = BIT_CYC_MIN * LOW_BITS * (100 - TOL_PCT) / 100;

  // Cycle offset of bit k (its centre when mid is set)
  function automatic logic [CNT_W-1:0] bit_point(
    input logic [PER_W-1:0] p,
    input logic [3:0]       k,
    input logic             mid
  );
    bit_point = CNT_W'(p) * CNT_W'(k) + (mid ? CNT_W'(p >> 1) : '0);
  endfunction : bit_point
endpackage : tksrp_pkg

// ============================================================
// Auto-baud request receiver
module tksrp_rx #(
  parameter logic [tksrp_pkg::CNT_W-1:0] LOW_MIN = '0,
  parameter logic [tksrp_pkg::CNT_W-1:0] LOW_MAX = '1
) (
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire logic                        line,
  input  wire logic                        en,
  output logic                             busy,
  output logic                             done,
  output logic [tksrp_pkg::PER_W-1:0]      period
);
  typedef enum logic [1:0] {RX_IDLE, RX_LOW, RX_BITS} tksrp_rx_t;
  localparam logic [9:0] FRAME = {1'b1, tksrp_pkg::REQ_CHAR, 1'b0};

  tksrp_rx_t                    state_reg, state_next;
  logic [tksrp_pkg::CNT_W-1:0]  cnt_reg, cnt_next;
  logic [3:0]                   idx_reg, idx_next;
  logic [tksrp_pkg::PER_W-1:0]  per_reg, per_next;
  logic                         done_reg, done_next;
  logic                         prev_reg;

  // Low time of start plus four zeros gives five bit periods
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg + 1'b1;
    idx_next   = idx_reg;
    per_next   = per_reg;
    done_next  = 1'b0;
    case (state_reg)
      RX_IDLE:
      begin
        cnt_next = '0;
        if (en && prev_reg && !line)
          state_next = RX_LOW;
      end
      RX_LOW:
      begin
        if (cnt_reg > LOW_MAX)
          state_next = RX_IDLE;                 // Below the slowest rate
        else if (line)
        begin
          if (cnt_reg < LOW_MIN)
            state_next = RX_IDLE;               // Glitch or too fast
          else
          begin
            // Count lags the low time by one cycle, so add it back
            per_next   = tksrp_pkg::PER_W'((cnt_reg + 1'b1) /
                         tksrp_pkg::CNT_W'(tksrp_pkg::LOW_BITS));
            idx_next   = tksrp_pkg::FIRST_HIGH;
            state_next = RX_BITS;
          end
        end
      end
      RX_BITS:
      begin
        // Check each later bit at its centre against the fixed pattern
        if (cnt_reg == tksrp_pkg::bit_point(per_reg, idx_reg, 1'b1))
        begin
          if (line != FRAME[idx_reg])
            state_next = RX_IDLE;               // Not the request character
          else if (idx_reg == tksrp_pkg::STOP_IDX)
          begin
            done_next  = 1'b1;
            state_next = RX_IDLE;
          end
          else
            idx_next = idx_reg + 1'b1;
        end
      end
      default: state_next = RX_IDLE;
    endcase
  end

  // Registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= RX_IDLE;
      cnt_reg   <= '0;
      idx_reg   <= '0;
      per_reg   <= '0;
      done_reg  <= 1'b0;
      prev_reg  <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      idx_reg   <= idx_next;
      per_reg   <= per_next;
      done_reg  <= done_next;
      prev_reg  <= line;
    end
  end

  assign busy   = (state_reg != RX_IDLE);
  assign done   = done_reg;
  assign period = per_reg;
endmodule : tksrp_rx

`default_nettype wire

/* tksrp_port.sv */
/*
  Touch-key serial reply port: auto-baud request detection, turnaround,
  two-byte key reply, change flag and any-touch outputs, burst abort/rerun.
  Assumes key states, sleep and wake-check levels come from on-chip logic
  on CLK_SYS; the two serial pins are asynchronous and are synchronised.
*/
// Overview of operation
// - Bit rate is measured from the host's known request character.
// - Any host rate from 8,000 to 38,400 bit/s is accepted.
// - Frames are one start, eight data, no parity, one stop bit.
// - Reply goes out at the rate measured from the latest request.
// - Device starts driving one to three bit periods after the stop bit.
// - Change flag returns released-high before the reply starts.
// - Reply is two bytes, 0x40 plus one bit per touched key.
// - Reply is push-pull; the line is released halfway through each stop bit.
// - A request during a burst aborts it; rerun after the reply.
// - While sleeping, requests are taken only during wake-up checks or with change flag or any-touch active.
// - With change flag or any-touch active, every request is answered.
// - Split receive mode takes requests on a receive-only pin.
// - Unused keys are ignored for all outputs and suppression.
// - Change flag goes low on any touch or release until polled.
// - Any-touch output is the OR of the used key states.
`timescale 1ns/10ps
`default_nettype none

module tksrp_port #(
  parameter int LOW_MIN_CYC = tksrp_pkg::LOW_MIN_CYC,
  parameter int LOW_MAX_CYC = tksrp_pkg::LOW_MAX_CYC
) (
  input  wire logic                          CLK_SYS,
  input  wire logic                          RST_B,
  input  wire logic                          SHARED_SERIAL_LINE_IN,
  output logic                               SHARED_SERIAL_LINE_OUT,
  output logic                               SHARED_SERIAL_LINE_OE,
  input  wire logic                          SPLIT_RX_IN,
  input  wire logic                          SPLIT_RECEIVE_MODE,
  input  wire logic [tksrp_pkg::KEY_N-1:0]   KEY_STATE,
  input  wire logic [tksrp_pkg::KEY_N-1:0]   KEY_USED,
  input  wire logic                          LOW_POWER_SLEEP,
  input  wire logic                          WAKE_CHECK,
  input  wire logic                          BURST_ACTIVE,
  output logic                               CHANGE_PULL,
  output logic                               ANY_TOUCH,
  output logic                               BURST_ABORT,
  output logic                               BURST_RERUN
);
  typedef enum logic [1:0] {T_IDLE, T_TURN, T_SEND} tksrp_state_t;
  localparam int KW = tksrp_pkg::KEY_N - tksrp_pkg::KEY_LO_N;

  // ============================================================
  // Pin synchronisers
  logic [1:0] sh_sync_reg;
  logic [1:0] rx_sync_reg;

  // Two stages each; only stage two is read by logic
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      sh_sync_reg <= 2'h3;
      rx_sync_reg <= 2'h3;
    end
    else
    begin
      sh_sync_reg <= {sh_sync_reg[0], SHARED_SERIAL_LINE_IN};
      rx_sync_reg <= {rx_sync_reg[0], SPLIT_RX_IN};
    end
  end

  // ============================================================
  // Request receiver
  tksrp_state_t                state_reg, state_next;
  logic                        change_reg, change_next;
  logic                        any_reg, any_next;
  logic                        rx_line, rx_en, rx_busy, rx_done;
  logic [tksrp_pkg::PER_W-1:0] rx_period;
  logic [tksrp_pkg::KEY_N-1:0] keys_live;

  assign keys_live = KEY_STATE & KEY_USED;
  // Split mode listens on the receive-only pin, never driven
  assign rx_line   = SPLIT_RECEIVE_MODE ? rx_sync_reg[1] : sh_sync_reg[1];
  // Sleeping device hears requests only when awake or flagged
  assign rx_en     = (state_reg == T_IDLE) &&
                     (!LOW_POWER_SLEEP || WAKE_CHECK ||
                      change_reg || any_reg);

  tksrp_rx #(
    .LOW_MIN (tksrp_pkg::CNT_W'(LOW_MIN_CYC)),
    .LOW_MAX (tksrp_pkg::CNT_W'(LOW_MAX_CYC))
  ) u_rx (
    .clk    (CLK_SYS),
    .rst_b  (RST_B),
    .line   (rx_line),
    .en     (rx_en),
    .busy   (rx_busy),
    .done   (rx_done),
    .period (rx_period)
  );

  // ============================================================
  // Reply sequencer
  logic [tksrp_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic [3:0]                  idx_reg, idx_next;
  logic                        sel_reg, sel_next;
  logic [9:0]                  frame_reg, frame_next;
  logic [7:0]                  hold_reg, hold_next;
  logic [tksrp_pkg::PER_W-1:0] per_reg, per_next;
  logic [tksrp_pkg::KEY_N-1:0] prev_reg;
  logic                        out_reg, out_next;
  logic                        oe_reg, oe_next;
  logic                        busy_d_reg;
  logic                        aborted_reg, aborted_next;
  logic                        abort_reg, abort_next;
  logic                        rerun_reg, rerun_next;
  logic                        key_change, bit_end;

  assign key_change = (keys_live != prev_reg);
  assign bit_end    = (cnt_reg ==
                       tksrp_pkg::bit_point(per_reg, 4'h1, 1'b0) - 1'b1);

  // Next-state, reply bytes and pin drive all derive from here
  always_comb
  begin
    state_next   = state_reg;
    cnt_next     = cnt_reg + 1'b1;
    idx_next     = idx_reg;
    sel_next     = sel_reg;
    frame_next   = frame_reg;
    hold_next    = hold_reg;
    per_next     = per_reg;
    aborted_next = aborted_reg;
    abort_next   = 1'b0;
    rerun_next   = 1'b0;
    any_next     = |keys_live;
    change_next  = change_reg;
    // Overlapping request aborts the running burst
    if (rx_busy && !busy_d_reg && BURST_ACTIVE)
    begin
      abort_next   = 1'b1;
      aborted_next = 1'b1;
    end
    case (state_reg)
      T_IDLE:
      begin
        cnt_next = '0;
        if (rx_done)
        begin
          per_next    = rx_period;
          state_next  = T_TURN;
          change_next = 1'b0;
        end
      end
      T_TURN:
      begin
        // Done fires mid stop bit, so two periods land 1.5 after it
        if (cnt_reg == tksrp_pkg::bit_point(per_reg,
            4'(tksrp_pkg::TURN_BITS), 1'b0) - 1'b1)
        begin
          cnt_next   = '0;
          idx_next   = '0;
          sel_next   = 1'b0;
          state_next = T_SEND;
          frame_next = {1'b1, tksrp_pkg::IDLE_REPLY |
                        8'(keys_live[tksrp_pkg::KEY_LO_N-1:0]), 1'b0};
          hold_next  = tksrp_pkg::IDLE_REPLY |
                       8'(keys_live[tksrp_pkg::KEY_LO_N +: KW]);
        end
      end
      T_SEND:
      begin
        if (bit_end)
        begin
          cnt_next = '0;
          if (idx_reg != tksrp_pkg::STOP_IDX)
            idx_next = idx_reg + 1'b1;
          else if (!sel_reg)
          begin
            idx_next   = '0;
            sel_next   = 1'b1;
            frame_next = {1'b1, hold_reg, 1'b0};
          end
          else
          begin
            state_next   = T_IDLE;
            rerun_next   = aborted_reg || abort_next;
            aborted_next = 1'b0;
          end
        end
      end
      default: state_next = T_IDLE;
    endcase
    // Set wins over the poll clear
    if (key_change)
      change_next = 1'b1;
    // Drive until half the stop bit, then let the pull-up hold it
    out_next = frame_next[idx_next];
    oe_next  = (state_next == T_SEND) &&
               !(idx_next == tksrp_pkg::STOP_IDX &&
                 cnt_next >= tksrp_pkg::bit_point(per_next, 4'h0,
                                                  1'b1));
  end

  // Registers
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state_reg   <= T_IDLE;
      cnt_reg     <= '0;
      idx_reg     <= '0;
      sel_reg     <= 1'b0;
      frame_reg   <= '1;
      hold_reg    <= '0;
      per_reg     <= '0;
      prev_reg    <= '0;
      out_reg     <= 1'b1;
      oe_reg      <= 1'b0;
      busy_d_reg  <= 1'b0;
      aborted_reg <= 1'b0;
      abort_reg   <= 1'b0;
      rerun_reg   <= 1'b0;
      change_reg  <= 1'b0;
      any_reg     <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      idx_reg     <= idx_next;
      sel_reg     <= sel_next;
      frame_reg   <= frame_next;
      hold_reg    <= hold_next;
      per_reg     <= per_next;
      prev_reg    <= keys_live;
      out_reg     <= out_next;
      oe_reg      <= oe_next;
      busy_d_reg  <= rx_busy;
      aborted_reg <= aborted_next;
      abort_reg   <= abort_next;
      rerun_reg   <= rerun_next;
      change_reg  <= change_next;
      any_reg     <= any_next;
    end
  end

  assign SHARED_SERIAL_LINE_OUT = out_reg;
  assign SHARED_SERIAL_LINE_OE  = oe_reg;
  assign CHANGE_PULL            = change_reg;
  assign ANY_TOUCH              = any_reg;
  assign BURST_ABORT            = abort_reg;
  assign BURST_RERUN            = rerun_reg;

  // ============================================================
  // Assertions
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  sequence s_req_taken;
    rx_done && state_reg == T_IDLE;
  endsequence
  sequence s_send_start;
    $rose(state_reg == T_SEND);
  endsequence

  a_req_to_turn: assert property (s_req_taken |=> state_reg == T_TURN)
    else $error("request not followed by turnaround");
  a_no_drive_turn: assert property (s_req_taken |=> (!oe_reg)[*2])
    else $error("line driven too soon after request");
  a_change_clear: assert property (s_req_taken and !key_change
    |=> !change_reg)
    else $error("change flag not released before reply");
  a_change_set: assert property (key_change |=> change_reg)
    else $error("key change did not raise change flag");
  a_any_touch: assert property (##1 any_reg == |$past(keys_live))
    else $error("any-touch output wrong");
  a_start_bit: assert property (s_send_start |-> oe_reg && !out_reg)
    else $error("reply did not open with a driven start bit");
  a_oe_in_send: assert property (oe_reg |-> state_reg == T_SEND)
    else $error("line driven outside a reply");
  a_sleep_ignore: assert property (!rx_busy && !rx_en |=> !rx_busy)
    else $error("request accepted while asleep");
  a_rate_held: assert property (state_reg != T_IDLE |=> $stable(per_reg))
    else $error("reply rate changed mid reply");
  a_rerun_end: assert property (rerun_reg |-> $past(state_reg) == T_SEND)
    else $error("burst rerun outside reply end");
endmodule : tksrp_port

`default_nettype wire

/* tksrp_host.sv */
/*
  Host model for the touch-key serial reply port: sends request
  characters and collects two-byte replies at a chosen bit period.
  Assumes the bench resolves the shared wire with a pull-up.
*/
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// Host model
module tksrp_host (
  input  wire logic clk,
  input  wire logic wire_lvl,
  output logic      sh_out,
  output logic      sh_oe,
  output logic      split_out
);
  // Idle: shared wire released, receive-only pin high
  initial
  begin
    sh_out    = 1'b1;
    sh_oe     = 1'b0;
    split_out = 1'b1;
  end

  // One frame LSB first, p cycles a bit, at any rate the bench picks
  task automatic send(input bit sp, input logic [7:0] ch, input int p);
    logic [9:0] fr;
    fr = {1'b1, ch, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk);
      #1;
      if (sp)
        split_out = fr[i];
      else
      begin
        sh_oe  = 1'b1;
        sh_out = fr[i];
      end
      repeat (p - 1) @(posedge clk);
    end
    // Push-pull drive dropped as the stop bit ends, avoiding a clash
    @(posedge clk);
    #1;
    sh_oe  = 1'b0;
    sh_out = 1'b1;
  endtask : send

  // Reply collector; a missing start within 4 bits means no answer
  task automatic recv(input int p, output logic [15:0] r, output bit ok,
                      output int gap);
    ok  = 1'b1;
    gap = 0;
    r   = '0;
    for (int b = 0; b < 2; b++)
    begin
      int w;
      w = 0;
      do
      begin
        @(posedge clk);
        #2;
        w++;
      end
      while (wire_lvl !== 1'b0 && w < 4 * p);
      if (b == 0)
        gap = w;
      if (wire_lvl !== 1'b0)
      begin
        ok = 1'b0;
        return;
      end
      repeat (p / 2) @(posedge clk);
      for (int k = 0; k < 9; k++)
      begin
        repeat (p) @(posedge clk);
        #2;
        if (k < 8)
          r[8 * b + k] = wire_lvl;
        else if (wire_lvl !== 1'b1)
          ok = 1'b0;
      end
    end
  endtask : recv
endmodule : tksrp_host
`default_nettype wire

/* tb_touch_key_serial_reply_port.sv */
/*
  Self-checking bench for the touch-key serial reply port.
  Assumes tksrp_host is compiled first; shared wire has a pull-up.
*/
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// Bench top
module tb_touch_key_serial_reply_port;
  localparam int TMO = 60000;
  logic       clk_sys = 1'b0;
  logic       rst_b   = 1'b0;
  logic       split_m = 1'b0;
  logic [9:0] keys    = 10'h000;
  logic [9:0] used    = 10'h3ff;
  logic       sleep   = 1'b0;
  logic       wake    = 1'b0;
  logic       burst   = 1'b0;
  logic       dev_out;
  logic       dev_oe;
  logic       chg;
  logic       any_t;
  logic       abort_p;
  logic       rerun_p;
  logic       h_out;
  logic       h_oe;
  logic       h_split;
  logic       line;
  int         n_fail;
  int         tests_run;
  int         n_abort;
  int         n_rerun;
  int         n_clash;
  int         n_fight;
  int         cyc;

  // Pull-up wins when neither side drives
  assign line = dev_oe ? dev_out : (h_oe ? h_out : 1'b1);

  always #2.5 clk_sys = ~clk_sys;

  tksrp_port #(
    .LOW_MIN_CYC (20),
    .LOW_MAX_CYC (400)
  ) tksrp_port_i (
    .CLK_SYS                (clk_sys),
    .RST_B                  (rst_b),
    .SHARED_SERIAL_LINE_IN  (line),
    .SHARED_SERIAL_LINE_OUT (dev_out),
    .SHARED_SERIAL_LINE_OE  (dev_oe),
    .SPLIT_RX_IN            (h_split),
    .SPLIT_RECEIVE_MODE     (split_m),
    .KEY_STATE              (keys),
    .KEY_USED               (used),
    .LOW_POWER_SLEEP        (sleep),
    .WAKE_CHECK             (wake),
    .BURST_ACTIVE           (burst),
    .CHANGE_PULL            (chg),
    .ANY_TOUCH              (any_t),
    .BURST_ABORT            (abort_p),
    .BURST_RERUN            (rerun_p)
  );

  tksrp_host tksrp_host_i (
    .clk       (clk_sys),
    .wire_lvl  (line),
    .sh_out    (h_out),
    .sh_oe     (h_oe),
    .split_out (h_split)
  );

  task automatic wrap_up;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  // Pulse counters, flag-while-driving watch and hang guard
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (abort_p === 1'b1) n_abort <= n_abort + 1;
    if (rerun_p === 1'b1) n_rerun <= n_rerun + 1;
    if (dev_oe === 1'b1 && chg === 1'b1) n_clash <= n_clash + 1;
    if (dev_oe === 1'b1 && h_oe === 1'b1) n_fight <= n_fight + 1;
    if (cyc == TMO)
    begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string msg);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s: got %h want %h", $time, msg, seen, exp);
    end
  endtask : check

  // Request plus reply; the extra wait lets the reply end before reuse
  task automatic xact(input bit sp, input logic [7:0] ch, input int p,
                      output logic [15:0] r, output bit ok);
    int gap;
    tksrp_host_i.send(sp, ch, p);
    tksrp_host_i.recv(p, r, ok, gap);
    repeat (p) @(posedge clk_sys);
    #1;
    if (ok)
    begin
      check(16'(gap >= p && gap <= 3 * p), 16'h1, "turnaround");
      check({15'h0, dev_oe}, 16'h0, "line released");
    end
  endtask : xact

  task automatic settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : settle

  task automatic t_reset;
    check({14'h0, dev_oe, chg}, 16'h0, "reset oe and flag");
    check({13'h0, any_t, abort_p, rerun_p}, 16'h0, "reset touch");
    $display("test reset done");
  endtask : t_reset

  task automatic t_keys;
    logic [15:0] r;
    bit          ok;
    keys = 10'h085;
    settle();
    check({15'h0, chg}, 16'h1, "flag set");
    check({15'h0, any_t}, 16'h1, "any touch");
    xact(1'b0, 8'h50, 20, r, ok);
    check(r, 16'h4245, "keys 0 2 7");
    check({15'h0, chg}, 16'h0, "flag released");
    check(16'(n_clash), 16'h0, "flag during reply");
    check(16'(n_fight), 16'h0, "drive conflict");
    $display("test keys done");
  endtask : t_keys

  task automatic t_mask_rate;
    logic [15:0] r;
    bit          ok;
    used = 10'h2db;
    keys = 10'h024;
    settle();
    check({15'h0, any_t}, 16'h0, "unused keys");
    xact(1'b0, 8'h50, 40, r, ok);
    check(r, 16'h4040, "unused masked");
    keys = 10'h3ff;
    xact(1'b0, 8'h50, 40, r, ok);
    check(r, 16'h4b5b, "slow rate reply");
    used = 10'h3ff;
    $display("test mask_rate done");
  endtask : t_mask_rate

  task automatic t_split;
    logic [15:0] r;
    bit          ok;
    split_m = 1'b1;
    keys    = 10'h200;
    xact(1'b1, 8'h50, 30, r, ok);
    check(r, 16'h4840, "split reply");
    xact(1'b0, 8'h50, 30, r, ok);
    check({15'h0, ok}, 16'h0, "shared ignored");
    split_m = 1'b0;
    $display("test split done");
  endtask : t_split

  task automatic t_abort;
    logic [15:0] r;
    bit          ok;
    burst   = 1'b1;
    n_abort = 0;
    n_rerun = 0;
    xact(1'b0, 8'h50, 20, r, ok);
    burst = 1'b0;
    check(16'(n_abort), 16'h1, "abort pulse");
    check(16'(n_rerun), 16'h1, "rerun pulse");
    $display("test abort done");
  endtask : t_abort

  task automatic t_bad;
    logic [15:0] r;
    bit          ok;
    xact(1'b0, 8'hd0, 20, r, ok);
    check({15'h0, ok}, 16'h0, "wrong char");
    $display("test bad done");
  endtask : t_bad

  task automatic t_sleep;
    logic [15:0] r;
    bit          ok;
    keys = 10'h000;
    xact(1'b0, 8'h50, 20, r, ok);
    check(r, 16'h4040, "flag cleared");
    sleep = 1'b1;
    xact(1'b0, 8'h50, 20, r, ok);
    check({15'h0, ok}, 16'h0, "asleep");
    wake = 1'b1;
    xact(1'b0, 8'h50, 20, r, ok);
    check(r, 16'h4040, "wake check");
    wake = 1'b0;
    keys = 10'h001;
    settle();
    xact(1'b0, 8'h50, 20, r, ok);
    check(r, 16'h4041, "touch keeps awake");
    sleep = 1'b0;
    $display("test sleep done");
  endtask : t_sleep

  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    settle();
    t_reset();
    t_keys();
    t_mask_rate();
    t_split();
    t_abort();
    t_bad();
    t_sleep();
    wrap_up();
  end
endmodule : tb_touch_key_serial_reply_port
`default_nettype wire
